// [rtl/acmp_pkg.sv]
/*
  Shared constants of the analog comparator control block: register map,
  bit positions, edge-mode codes, reset values and AXI response codes.
  Assumes a 32-bit AXI4-Lite register bus with one register per aligned word.
*/
package acmp_pkg;

  // Register map (byte addresses)
  localparam logic [31:0] CTRL_STATUS_ADDR = 32'h0000_0008;
  localparam int          ADDR_W           = 32;
  localparam int          DATA_W           = 32;
  localparam int          REG_W            = 8;

  // Bit positions in comparator_control_status
  localparam int BIT_POWER_OFF   = 7;
  localparam int BIT_RESERVED    = 6;
  localparam int BIT_RESULT      = 5;
  localparam int BIT_EVENT_FLAG  = 4;
  localparam int BIT_IRQ_ENABLE  = 3;
  localparam int BIT_CAPTURE_SEL = 2;
  localparam int BIT_EDGE_SEL_HI = 1;
  localparam int BIT_EDGE_SEL_LO = 0;

  // Edge select codes
  localparam logic [1:0] EDGE_TOGGLE   = 2'h0;
  localparam logic [1:0] EDGE_RESERVED = 2'h1;
  localparam logic [1:0] EDGE_FALL     = 2'h2;
  localparam logic [1:0] EDGE_RISE     = 2'h3;

  // Reset values of writable fields
  localparam logic       RST_POWER_OFF  = 1'h0;
  localparam logic       RST_EVENT_FLAG = 1'h0;
  localparam logic       RST_IRQ_ENABLE = 1'h0;
  localparam logic       RST_CAPTURE    = 1'h0;
  localparam logic [1:0] RST_EDGE_SEL   = 2'h0;

  // AXI response codes
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : acmp_pkg

// [rtl/cmp_sync.sv]
/*
  Two-flop synchroniser for one level coming from outside the clock domain.
  Assumes the input is a slowly changing level, not a short pulse.
*/
module cmp_sync
(
  input  wire logic ref_clk,
  input  wire logic rst,
  input  wire logic asyncIn,
  output logic      syncOut
);

  typedef struct packed
  {
    logic first;
    logic second;
  } sync_s;

  sync_s s;
  sync_s next_s;

  // The first stage feeds only the second stage
  always_comb
  begin
    next_s.first  = asyncIn;
    next_s.second = s.first;
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
      s <= '0;
    else
      s <= next_s;
  end

  assign syncOut = s.second;

endmodule : cmp_sync

// [rtl/cmp_edge_detect.sv]
/*
  Edge matcher for the synchronised comparator level.
  Assumes level is already in the ref_clk domain; evt is combinational,
  one cycle wide, and must be registered by the parent.
*/
module cmp_edge_detect
(
  input  wire logic       ref_clk,
  input  wire logic       rst,
  input  wire logic       level,
  input  wire logic [1:0] mode,
  output logic            evt
);

  typedef struct packed
  {
    logic prev;
  } edge_s;

  edge_s s;
  edge_s next_s;

  // Match the change against the selected edge; the reserved code never fires
  always_comb
  begin
    next_s.prev = level;
    case (mode)
      acmp_pkg::EDGE_TOGGLE: evt = level ^ s.prev;
      acmp_pkg::EDGE_FALL:   evt = s.prev & ~level;
      acmp_pkg::EDGE_RISE:   evt = ~s.prev & level;
      default:               evt = 1'b0;
    endcase
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
      s <= '0;
    else
      s <= next_s;
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  a_rise_only: assert property (((mode == acmp_pkg::EDGE_RISE) && evt) |-> (level && !s.prev))
    else $error("rise event without a rising level");
  a_fall_only: assert property (((mode == acmp_pkg::EDGE_FALL) && evt) |-> ($fell(level)))
    else $error("fall event without a falling level");
  a_toggle_any: assert property ((mode == acmp_pkg::EDGE_TOGGLE) |-> (evt == (level != $past(level))))
    else $error("toggle event does not follow level change");
  a_reserved_mode: assert property ((mode == acmp_pkg::EDGE_RESERVED) |-> !evt)
    else $error("event raised in reserved mode");

endmodule : cmp_edge_detect

// [rtl/analog_comparator_control.sv]
/*
  Control and status logic around the on-chip voltage comparator, with one
  8-bit register reached over an AXI4-Lite slave.
  Assumes the comparator output and the capture pin are asynchronous levels,
  and that the global enable and vector acknowledge come from the CPU on ref_clk.
*/
// Implementation choice: the AXI4-Lite interface to the registers.
// How it works
// - Synchronised comparator result readable as status bit
// - Capture select routes comparator to timer capture
// - Mode chooses rise, fall or toggle event
// - Power-off bit switches comparator off, writable anytime
// - Bit 6 reserved, always reads zero
// - Matching output change sets the event flag
// - Request needs flag, enable and global enable
// - Vector acknowledge clears the event flag
// - Writing one clears flag, zero keeps it
module analog_comparator_control
(
  input  wire logic        ref_clk,
  input  wire logic        rst,
  // AXI4-Lite write address
  input  wire logic [31:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read address
  input  wire logic [31:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Comparator core and timer
  input  wire logic        cmpRawOut,
  input  wire logic        capturePin,
  output logic             cmpPowerOff,
  output logic             captureTrigger,
  // CPU interrupt interface
  input  wire logic        globalIrqEnable,
  input  wire logic        irqAck,
  output logic             irqRequest
);

  typedef struct packed
  {
    logic        awready;
    logic        wready;
    logic        awHeld;
    logic        wHeld;
    logic [31:0] awaddr;
    logic [7:0]  wdata;
    logic        wstrb0;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic        powerOff;
    logic        eventFlag;
    logic        irqEnable;
    logic        capSel;
    logic [1:0]  edgeSel;
    logic        irqRequest;
    logic        captureTrigger;
  } ctrl_s;

  ctrl_s       s;
  ctrl_s       next_s;
  logic        cmpLevel;
  logic        capLevel;
  logic        cmpEvent;
  logic        doWrite;
  logic        regHit;
  logic        clearByWrite;
  logic [7:0]  regView;

  // Address decode shared by the write and the read path
  function automatic logic isCtrlAddr(input logic [31:0] addr);
    isCtrlAddr = (addr == acmp_pkg::CTRL_STATUS_ADDR);
  endfunction : isCtrlAddr

  // Both external levels are asynchronous to ref_clk
  cmp_sync u_cmp_sync
  (
    .ref_clk (ref_clk),
    .rst     (rst),
    .asyncIn (cmpRawOut),
    .syncOut (cmpLevel)
  );

  cmp_sync u_cap_sync
  (
    .ref_clk (ref_clk),
    .rst     (rst),
    .asyncIn (capturePin),
    .syncOut (capLevel)
  );

  cmp_edge_detect u_edge
  (
    .ref_clk (ref_clk),
    .rst     (rst),
    .level   (cmpLevel),
    .mode    (s.edgeSel),
    .evt     (cmpEvent)
  );

  // Register image as software sees it
  always_comb
  begin
    regView                            = '0;
    regView[acmp_pkg::BIT_POWER_OFF]   = s.powerOff;
    regView[acmp_pkg::BIT_RESULT]      = cmpLevel;
    regView[acmp_pkg::BIT_EVENT_FLAG]  = s.eventFlag;
    regView[acmp_pkg::BIT_IRQ_ENABLE]  = s.irqEnable;
    regView[acmp_pkg::BIT_CAPTURE_SEL] = s.capSel;
    regView[acmp_pkg::BIT_EDGE_SEL_HI] = s.edgeSel[1];
    regView[acmp_pkg::BIT_EDGE_SEL_LO] = s.edgeSel[0];
  end

  // Bus slave, register file and interrupt logic in one next-state process
  always_comb
  begin
    next_s       = s;
    doWrite      = s.awHeld && s.wHeld && !s.bvalid;
    regHit       = isCtrlAddr(s.awaddr);
    clearByWrite = 1'b0;

    // Address and data are taken independently, in either order
    if (s.awready && s_axi_awvalid)
    begin
      next_s.awHeld = 1'b1;
      next_s.awaddr = s_axi_awaddr;
    end
    if (s.wready && s_axi_wvalid)
    begin
      next_s.wHeld  = 1'b1;
      next_s.wdata  = s_axi_wdata[7:0];
      next_s.wstrb0 = s_axi_wstrb[0];
    end

    // Commit once both halves are held; only byte lane 0 carries the register
    if (doWrite)
    begin
      next_s.awHeld = 1'b0;
      next_s.wHeld  = 1'b0;
      next_s.bvalid = 1'b1;
      next_s.bresp  = regHit ? acmp_pkg::RESP_OKAY : acmp_pkg::RESP_SLVERR;
      if (regHit && s.wstrb0)
      begin
        next_s.powerOff  = s.wdata[acmp_pkg::BIT_POWER_OFF];
        next_s.irqEnable = s.wdata[acmp_pkg::BIT_IRQ_ENABLE];
        next_s.capSel    = s.wdata[acmp_pkg::BIT_CAPTURE_SEL];
        next_s.edgeSel   = {s.wdata[acmp_pkg::BIT_EDGE_SEL_HI],
                            s.wdata[acmp_pkg::BIT_EDGE_SEL_LO]};
        clearByWrite     = s.wdata[acmp_pkg::BIT_EVENT_FLAG];
      end
    end
    else if (s.bvalid && s_axi_bready)
    begin
      next_s.bvalid = 1'b0;
    end
    // Each ready only while its own channel holds nothing and no response waits, so a second write waits its turn
    next_s.awready = !next_s.awHeld && !next_s.bvalid;
    next_s.wready  = !next_s.wHeld && !next_s.bvalid;

    // Read path answers on the cycle after the address is taken
    if (s.arready && s_axi_arvalid)
    begin
      next_s.rvalid = 1'b1;
      if (isCtrlAddr(s_axi_araddr))
      begin
        next_s.rdata = {24'h00_0000, regView};
        next_s.rresp = acmp_pkg::RESP_OKAY;
      end
      else
      begin
        next_s.rdata = 32'h0000_0000;
        next_s.rresp = acmp_pkg::RESP_SLVERR;
      end
    end
    else if (s.rvalid && s_axi_rready)
    begin
      next_s.rvalid = 1'b0;
    end
    next_s.arready = !next_s.rvalid;

    // A new event beats a clear in the same cycle, so it is never lost
    if (cmpEvent)
      next_s.eventFlag = 1'b1;
    else if (irqAck || clearByWrite)
      next_s.eventFlag = 1'b0;

    // Request is gated by the flag, the local enable and the CPU enable
    next_s.irqRequest = s.eventFlag && s.irqEnable && globalIrqEnable && !irqAck;

    // Capture input comes from the comparator or the pin
    next_s.captureTrigger = s.capSel ? cmpLevel : capLevel;
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      s           <= '0;
      s.powerOff  <= acmp_pkg::RST_POWER_OFF;
      s.eventFlag <= acmp_pkg::RST_EVENT_FLAG;
      s.irqEnable <= acmp_pkg::RST_IRQ_ENABLE;
      s.capSel    <= acmp_pkg::RST_CAPTURE;
      s.edgeSel   <= acmp_pkg::RST_EDGE_SEL;
    end
    else
    begin
      s <= next_s;
    end
  end

  // All outputs straight from the state register
  assign s_axi_awready  = s.awready;
  assign s_axi_wready   = s.wready;
  assign s_axi_bvalid   = s.bvalid;
  assign s_axi_bresp    = s.bresp;
  assign s_axi_arready  = s.arready;
  assign s_axi_rvalid   = s.rvalid;
  assign s_axi_rdata    = s.rdata;
  assign s_axi_rresp    = s.rresp;
  assign cmpPowerOff    = s.powerOff;   // Analog core powers down while high
  assign captureTrigger = s.captureTrigger;
  assign irqRequest     = s.irqRequest;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  sequence ctrlWriteBits;
    doWrite && regHit && s.wstrb0;
  endsequence

  sequence bothHalvesTaken;
    (s.awready && s_axi_awvalid) && (s.wready && s_axi_wvalid);
  endsequence

  a_result_read: assert property ((s.arready && s_axi_arvalid && isCtrlAddr(s_axi_araddr))
                                  |=> (s_axi_rdata[acmp_pkg::BIT_RESULT] == $past(cmpLevel)))
    else $error("status bit does not show comparator result");
  a_capture_route: assert property ($past(s.capSel) |-> (captureTrigger == $past(cmpLevel)))
    else $error("capture trigger not routed from comparator");
  a_capture_pin: assert property (!$past(s.capSel) |-> (captureTrigger == $past(capLevel)))
    else $error("capture trigger not routed from pin");
  a_power_write: assert property (ctrlWriteBits |=> (cmpPowerOff == $past(s.wdata[acmp_pkg::BIT_POWER_OFF])))
    else $error("power-off bit not updated by write");
  a_reserved_zero: assert property (s_axi_rvalid |-> !s_axi_rdata[acmp_pkg::BIT_RESERVED])
    else $error("reserved bit read as one");
  a_flag_sets: assert property (cmpEvent |=> s.eventFlag)
    else $error("event flag not set by matching edge");
  a_irq_gate: assert property (irqRequest |-> $past(s.eventFlag && s.irqEnable && globalIrqEnable))
    else $error("interrupt request without flag and enables");
  a_irq_raise: assert property ((s.eventFlag && s.irqEnable && globalIrqEnable && !irqAck) |=> irqRequest)
    else $error("interrupt request missing");
  a_ack_clears: assert property ((irqAck && !cmpEvent) |=> !s.eventFlag)
    else $error("flag not cleared on vector acknowledge");
  a_zero_keeps: assert property ((ctrlWriteBits and (!s.wdata[acmp_pkg::BIT_EVENT_FLAG] && s.eventFlag && !irqAck))
                                 |=> s.eventFlag)
    else $error("writing zero cleared the flag");
  a_one_clears: assert property ((ctrlWriteBits and (s.wdata[acmp_pkg::BIT_EVENT_FLAG] && !cmpEvent))
                                 |=> !s.eventFlag)
    else $error("writing one did not clear the flag");
  a_write_answer: assert property (bothHalvesTaken |-> ##[1:2] s_axi_bvalid)
    else $error("write response late");

  sequence readTaken;
    s.arready && s_axi_arvalid;
  endsequence

  // Bus answers stand until the master takes them, so a slow master loses nothing
  a_read_answer: assert property (readTaken |=> s_axi_rvalid)
    else $error("read data not presented");
  a_read_holds: assert property ((s_axi_rvalid && !s_axi_rready) |=> (s_axi_rvalid && $stable(s_axi_rdata)))
    else $error("read data dropped before rready");
  a_write_holds: assert property ((s_axi_bvalid && !s_axi_bready) |=> (s_axi_bvalid && $stable(s_axi_bresp)))
    else $error("write response dropped before bready");

  // Side effects that only the edge matcher, the vector or a write may cause
  a_reserved_quiet: assert property (((s.edgeSel == acmp_pkg::EDGE_RESERVED) && !s.eventFlag)
                                     |=> !s.eventFlag)
    else $error("reserved edge code set the flag");
  a_ack_drops: assert property (irqAck |=> !irqRequest)
    else $error("interrupt request held through acknowledge");
  a_power_hold: assert property (!(doWrite && regHit && s.wstrb0) |=> $stable(cmpPowerOff))
    else $error("power-off bit changed without a write");

endmodule : analog_comparator_control

// [verification/cmp_core_model.sv]
/*
  Behavioural model of the analog comparator core.
  Assumes the bench sets both input voltages in millivolts off the clock edge.
*/
module cmp_core_model
(
  input  wire logic        cmpPowerOff,
  input  wire logic [11:0] posMv,
  input  wire logic [11:0] negMv,
  output logic             cmpRawOut
);
  timeunit 1ns;
  timeprecision 1ps;
  // A powered-down core reads low; that is the least helpful settled level
  always_comb cmpRawOut = !cmpPowerOff && (posMv > negMv);
endmodule : cmp_core_model

// [verification/tb_analog_comparator_control.sv]
/*
  Self-checking bench for the comparator control block.
  Assumes one 250 MHz clock and a single AXI4-Lite master in this bench.
*/
module tb_analog_comparator_control;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] ADDR = acmp_pkg::CTRL_STATUS_ADDR;
  logic ref_clk, rst, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, cmpRawOut, capturePin;
  logic cmpPowerOff, captureTrigger, globalIrqEnable, irqAck, irqRequest;
  logic [31:0] awaddr, wdata, araddr, rdata;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, resp;
  logic [11:0] posMv, negMv;
  logic [7:0]  rd;
  logic        capSel, pinVal;
  int          n_fail, samples_checked;

  analog_comparator_control analog_comparator_control_inst (.ref_clk(ref_clk), .rst(rst),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .cmpRawOut(cmpRawOut), .capturePin(capturePin), .cmpPowerOff(cmpPowerOff),
    .captureTrigger(captureTrigger), .globalIrqEnable(globalIrqEnable), .irqAck(irqAck),
    .irqRequest(irqRequest));
  cmp_core_model cmp_core_model_inst (.cmpPowerOff(cmpPowerOff), .posMv(posMv), .negMv(negMv),
    .cmpRawOut(cmpRawOut));

  // Free-running clock
  initial
  begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic report_and_stop;
    $display("checked=%0d failed=%0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : report_and_stop

  // Holds each channel until its own ready; an extra edge keeps bready from two writes in one step
  task automatic axi_write(input logic [31:0] a, input logic [7:0] d, input logic [3:0] s);
    awaddr <= a;
    wdata <= {24'h00_0000, d};
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    // Only the watchdog ends a wait for the answer
    do
    begin
      @(posedge ref_clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end
    while (bvalid !== 1'b1);
    resp = bresp;
    bready <= 1'b0;
    @(posedge ref_clk);
  endtask : axi_write

  task automatic axi_read(input logic [31:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge ref_clk);
      if (arvalid && arready) arvalid <= 1'b0;
    end
    while (rvalid !== 1'b1);
    rd = rdata[7:0];
    resp = rresp;
    chk(rdata[31:8], 24'h00_0000);
    rready <= 1'b0;
    @(posedge ref_clk);
  endtask : axi_read

  function automatic logic [7:0] exp_reg(logic pwr, logic res, logic flag, logic ie, logic cap,
                                         logic [1:0] m);
    return {pwr, 1'b0, res, flag, ie, cap, m};
  endfunction : exp_reg

  // Moves the comparator inputs to a random level on the wanted side, then lets the synchroniser fill
  task automatic set_cmp(input logic hi);
    negMv <= 12'h400;
    posMv <= hi ? 12'h401 + 12'($urandom_range(0, 500)) : 12'($urandom_range(0, 12'h3ff));
    repeat (8) @(posedge ref_clk);
  endtask : set_cmp

  initial
  begin
    repeat (20000) @(posedge ref_clk);
    n_fail++;
    report_and_stop();
  end

  initial
  begin
    void'($urandom(32'h84ce_077d));
    n_fail = 0;
    samples_checked = 0;
    rst = 1'b1;
    awvalid = 1'b0;
    wvalid = 1'b0;
    bready = 1'b0;
    arvalid = 1'b0;
    rready = 1'b0;
    awaddr = 32'h0000_0000;
    wdata = 32'h0000_0000;
    wstrb = 4'h0;
    araddr = 32'h0000_0000;
    capturePin = 1'b0;
    globalIrqEnable = 1'b0;
    irqAck = 1'b0;
    posMv = 12'h000;
    negMv = 12'h400;
    repeat (10) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (3) @(posedge ref_clk);
    axi_read(ADDR);
    chk({rd, resp}, {8'h00, acmp_pkg::RESP_OKAY});
    // Unmapped places answer with an error and zero data
    axi_read(32'h0000_000C);
    chk({rd, resp}, {8'h00, acmp_pkg::RESP_SLVERR});
    axi_write(32'h0000_000C, 8'h8F, 4'hF);
    chk(resp, acmp_pkg::RESP_SLVERR);
    axi_write(ADDR, 8'h4E, 4'hF);
    chk(resp, acmp_pkg::RESP_OKAY);
    axi_read(ADDR);
    chk(rd, 8'h0E);
    axi_write(ADDR, 8'h81, 4'hE);
    axi_read(ADDR);
    chk(rd, 8'h0E);
    // Every edge code, rising then falling change; writing back a read image drops a set flag
    for (int m = 0; m < 4; m++)
    begin
      set_cmp(1'b0);
      axi_write(ADDR, 8'h10 | 8'(m), 4'hF);
      set_cmp(1'b1);
      axi_read(ADDR);
      chk(rd, exp_reg(0, 1, m == 0 || m == 3, 0, 0, 2'(m)));
      axi_write(ADDR, 8'(m), 4'hF);
      axi_read(ADDR);
      chk(rd, exp_reg(0, 1, m == 0 || m == 3, 0, 0, 2'(m)));
      axi_write(ADDR, rd, 4'hF);
      chk(resp, acmp_pkg::RESP_OKAY);
      axi_read(ADDR);
      chk(rd, exp_reg(0, 1, 0, 0, 0, 2'(m)));
      axi_write(ADDR, 8'h10 | 8'(m), 4'hF);
      set_cmp(1'b0);
      axi_read(ADDR);
      chk(rd, exp_reg(0, 0, m == 0 || m == 2, 0, 0, 2'(m)));
    end
    // Request follows the global enable while flag and enable are set; the vector acknowledge clears it
    for (int g = 0; g < 2; g++)
    begin
      globalIrqEnable <= g[0];
      axi_write(ADDR, 8'h1B, 4'hF);
      set_cmp(1'b1);
      chk(irqRequest, g[0]);
      irqAck <= 1'b1;
      @(posedge ref_clk);
      irqAck <= 1'b0;
      repeat (2) @(posedge ref_clk);
      chk(irqRequest, 1'b0);
      axi_read(ADDR);
      chk(rd, exp_reg(0, 1, 0, 1, 0, acmp_pkg::EDGE_RISE));
      set_cmp(1'b0);
    end
    // Capture source follows the select bit
    for (int i = 0; i < 8; i++)
    begin
      capSel = 1'($urandom);
      pinVal = 1'($urandom);
      axi_write(ADDR, {5'h00, capSel, 2'h0}, 4'hF);
      capturePin <= pinVal;
      set_cmp(1'($urandom));
      chk(captureTrigger, capSel ? (posMv > negMv) : pinVal);
    end
    // Interrupt enable is already clear before the power bit changes
    axi_write(ADDR, 8'h80, 4'hF);
    chk(cmpPowerOff, 1'b1);
    // A core that is off reads low; the flag depends on every random level of the capture loop, so it is masked
    axi_read(ADDR);
    chk(rd & 8'hEF, 8'h80);
    axi_write(ADDR, 8'h00, 4'hF);
    chk(cmpPowerOff, 1'b0);
    report_and_stop();
  end
endmodule : tb_analog_comparator_control
